// [design/umh_pin_logic.sv]
// Host bus, modem handshake, interrupt and clock pin logic
//
// Operation
// RULE1 - Eight-bit tri-state data bus to host
// RULE2 - Status bit 7 shows carrier detect level
// RULE3 - Status bit 3 flags carrier change, interrupts
// RULE4 - Status bit 5 shows data set ready
// RULE5 - Status bit 1 flags ready change, interrupts
// RULE6 - Driver disable high except during reads
// RULE7 - Control bit set drives terminal ready low
// RULE8 - Terminal ready high: reset, loopback, cleared
// RULE9 - Interrupt from four cause groups
// RULE10 - Interrupt drops when serviced or reset
// RULE11 - Master reset clears registers and outputs
// RULE12 - Control bits drive user outputs low
// RULE13 - User outputs high: reset, loopback, cleared
// RULE14 - Receiver timed from sixteen-times clock input
// RULE15 - Host selects with a, b high, c low
// RULE16 - Baud divider makes sixteen-times clock
// RULE17 - Status read clears change flags
// RULE18 - Data drivers off outside selected reads
`timescale 1ns/1ps
`default_nettype none

module umh_pin_logic
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire umh_pkg::umh_host_req_t host_in,
  input wire umh_pkg::umh_modem_pins_t modem_in,
  input wire umh_pkg::umh_core_evt_t core_in,
  output logic [umh_pkg::DATA_W-1:0] data_out,
  output logic data_oe_out,
  output logic bus_driver_disable_out,
  output logic dtr_n_out,
  output logic user_output_a_n_out,
  output logic user_output_b_n_out,
  output logic irq_out,
  output logic baud_clock_out,
  output logic rx_sample_tick_out,
  output logic rx_bit_tick_out
);

  // Chip decode
  logic selected; // All three selects active
  logic rd_hit; // Selected read strobe
  logic wr_hit; // Selected write strobe

  // Software registers
  logic [umh_pkg::CTRL_W-1:0] modem_control_reg; // Modem control
  logic [umh_pkg::IRQ_W-1:0] mask_reg; // Interrupt enables
  logic [umh_pkg::IRQ_W-1:0] ists_reg; // Sticky causes
  logic [umh_pkg::DIV_W-1:0] div_reg; // Baud divisor
  logic loop_on; // Loopback mode

  // Read path
  logic [umh_pkg::DATA_W-1:0] rdata_reg; // Captured read data
  logic [umh_pkg::DATA_W-1:0] rdata_next; // Value to capture
  logic oe_reg; // Drives bus in answer cycle

  // Modem input synchronisers
  logic dcd_s1_reg; // First stage, carrier
  logic dcd_s2_reg; // Second stage, carrier
  logic dsr_s1_reg; // First stage, ready
  logic dsr_s2_reg; // Second stage, ready
  logic rclk_s1_reg; // First stage, rx clock
  logic rclk_s2_reg; // Second stage, rx clock
  logic rclk_old_reg; // Previous rx clock level

  // Modem status
  logic dcd_now; // Carrier, active high
  logic dsr_now; // Ready, active high
  logic dcd_old_reg; // Carrier one cycle ago
  logic dsr_old_reg; // Ready one cycle ago
  logic dcd_chg; // Carrier changed
  logic dsr_chg; // Ready changed
  logic carrier_change_flag_reg; // Carrier change flag
  logic ddsr_reg; // Ready change flag
  logic msr_read; // Status register read

  // Interrupt causes
  logic [umh_pkg::IRQ_W-1:0] cause; // Cause levels this cycle
  logic [umh_pkg::IRQ_W-1:0] w1c; // Bits written one

  // Baud divider and receive timing
  logic [umh_pkg::DIV_W-1:0] bcnt_reg; // Divider count
  logic baud_tick; // Divider wrapped
  logic rclk_rise; // External rx clock edge
  logic rx_tick; // Chosen receive tick
  logic [3:0] ovs_reg; // Oversample phase

  // Decode the three chip selects
  assign selected = host_in.cs_a & host_in.cs_b & ~host_in.cs_c_n; // RULE15
  assign rd_hit = selected & host_in.rd;
  assign wr_hit = selected & host_in.wr;
  assign loop_on = modem_control_reg[umh_pkg::CTRL_LOOP];

  // Modem control register
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      modem_control_reg <= umh_pkg::CTRL_RST; // RULE11
    end
    else if (wr_hit && host_in.addr == umh_pkg::OFF_MODEM_CTRL)
    begin
      modem_control_reg <= host_in.wdata[umh_pkg::CTRL_W-1:0];
    end
  end

  // Interrupt mask register
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mask_reg <= umh_pkg::IRQ_RST; // RULE11
    end
    else if (wr_hit && host_in.addr == umh_pkg::OFF_IRQ_MASK)
    begin
      mask_reg <= host_in.wdata[umh_pkg::IRQ_W-1:0];
    end
  end

  // Baud divisor, two byte halves
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      div_reg <= umh_pkg::DIV_RST;
    end
    else if (wr_hit && host_in.addr == umh_pkg::OFF_DIV_LO)
    begin
      div_reg[7:0] <= host_in.wdata;
    end
    else if (wr_hit && host_in.addr == umh_pkg::OFF_DIV_HI)
    begin
      div_reg[15:8] <= host_in.wdata;
    end
  end

  // Two flip-flops on every modem pin
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dcd_s1_reg <= 1'b1;
      dcd_s2_reg <= 1'b1;
      dsr_s1_reg <= 1'b1;
      dsr_s2_reg <= 1'b1;
      rclk_s1_reg <= 1'b0;
      rclk_s2_reg <= 1'b0;
    end
    else
    begin
      dcd_s1_reg <= modem_in.dcd_n;
      dcd_s2_reg <= dcd_s1_reg;
      dsr_s1_reg <= modem_in.dsr_n;
      dsr_s2_reg <= dsr_s1_reg;
      rclk_s1_reg <= modem_in.rclk;
      rclk_s2_reg <= rclk_s1_reg;
    end
  end

  // Loopback feeds control bits back as inputs
  always_comb
  begin
    if (loop_on)
    begin
      dcd_now = modem_control_reg[umh_pkg::CTRL_OUT_B];
      dsr_now = modem_control_reg[umh_pkg::CTRL_DTR];
    end
    else
    begin
      dcd_now = ~dcd_s2_reg; // RULE2
      dsr_now = ~dsr_s2_reg; // RULE4
    end
  end

  // Previous levels for change detection
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dcd_old_reg <= 1'b0;
      dsr_old_reg <= 1'b0;
    end
    else
    begin
      dcd_old_reg <= dcd_now;
      dsr_old_reg <= dsr_now;
    end
  end

  assign dcd_chg = dcd_now ^ dcd_old_reg; // RULE3
  assign dsr_chg = dsr_now ^ dsr_old_reg; // RULE5
  assign msr_read = rd_hit && host_in.addr == umh_pkg::OFF_MODEM_STAT;

  // Change flags; a new change beats the read clear
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      carrier_change_flag_reg <= 1'b0;
      ddsr_reg <= 1'b0;
    end
    else
    begin
      if (dcd_chg)
      begin
        carrier_change_flag_reg <= 1'b1; // RULE3
      end
      else if (msr_read)
      begin
        carrier_change_flag_reg <= 1'b0; // RULE17
      end
      if (dsr_chg)
      begin
        ddsr_reg <= 1'b1; // RULE5
      end
      else if (msr_read)
      begin
        ddsr_reg <= 1'b0; // RULE17
      end
    end
  end

  // Cause levels for the four interrupt groups
  always_comb
  begin
    cause = '0;
    cause[umh_pkg::IRQ_RX] = core_in.rx_ready |
      (core_in.rx_timeout & core_in.fifo_mode); // RULE9
    cause[umh_pkg::IRQ_THR] = core_in.thr_empty; // RULE9
    cause[umh_pkg::IRQ_LINE] = core_in.line_error; // RULE9
    cause[umh_pkg::IRQ_MODEM] = dcd_chg | dsr_chg; // RULE3 RULE5
  end

  // Bits the host writes one to clear
  always_comb
  begin
    w1c = '0;
    if (wr_hit && host_in.addr == umh_pkg::OFF_IRQ_STAT)
    begin
      w1c = host_in.wdata[umh_pkg::IRQ_W-1:0];
    end
  end

  // Sticky cause bits; a set beats a clear
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ists_reg <= umh_pkg::IRQ_RST; // RULE10
    end
    else
    begin
      ists_reg <= (ists_reg & ~w1c) | cause; // RULE10
    end
  end

  // One level output for unmasked causes
  assign irq_out = |(ists_reg & mask_reg); // RULE9

  // Read data selection
  always_comb
  begin
    rdata_next = umh_pkg::DATA_RST;
    if (host_in.addr == umh_pkg::OFF_IRQ_STAT)
    begin
      rdata_next[umh_pkg::IRQ_W-1:0] = ists_reg;
    end
    else if (host_in.addr == umh_pkg::OFF_IRQ_MASK)
    begin
      rdata_next[umh_pkg::IRQ_W-1:0] = mask_reg;
    end
    else if (host_in.addr == umh_pkg::OFF_DIV_LO)
    begin
      rdata_next = div_reg[7:0];
    end
    else if (host_in.addr == umh_pkg::OFF_DIV_HI)
    begin
      rdata_next = div_reg[15:8];
    end
    else if (host_in.addr == umh_pkg::OFF_MODEM_CTRL)
    begin
      rdata_next[umh_pkg::CTRL_W-1:0] = modem_control_reg;
    end
    else if (host_in.addr == umh_pkg::OFF_MODEM_STAT)
    begin
      rdata_next[umh_pkg::MSR_DCD] = dcd_now; // RULE2
      rdata_next[umh_pkg::MSR_DSR] = dsr_now; // RULE4
      rdata_next[umh_pkg::MSR_DDCD] = carrier_change_flag_reg; // RULE3
      rdata_next[umh_pkg::MSR_DDSR] = ddsr_reg; // RULE5
    end
  end

  // Read answer held for one cycle on the bus
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_reg <= umh_pkg::DATA_RST;
      oe_reg <= 1'b0; // RULE11
    end
    else
    begin
      oe_reg <= rd_hit; // RULE18
      if (rd_hit)
      begin
        rdata_reg <= rdata_next; // RULE1
      end
    end
  end

  // Bus pins; driver disable low only while answering
  assign data_out = rdata_reg; // RULE1
  assign data_oe_out = oe_reg; // RULE18
  assign bus_driver_disable_out = ~oe_reg; // RULE6

  // Modem control pins, active low
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dtr_n_out <= 1'b1; // RULE8
      user_output_a_n_out <= 1'b1; // RULE13
      user_output_b_n_out <= 1'b1; // RULE13
    end
    else
    begin
      dtr_n_out <=
        ~(modem_control_reg[umh_pkg::CTRL_DTR] & ~loop_on); // RULE7 RULE8
      user_output_a_n_out <=
        ~(modem_control_reg[umh_pkg::CTRL_OUT_A] & ~loop_on); // RULE12 RULE13
      user_output_b_n_out <=
        ~(modem_control_reg[umh_pkg::CTRL_OUT_B] & ~loop_on); // RULE12 RULE13
    end
  end

  // Baud divider; zero divisor stops it
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bcnt_reg <= umh_pkg::DIV_RST;
    end
    else if (div_reg == umh_pkg::DIV_RST)
    begin
      bcnt_reg <= umh_pkg::DIV_RST;
    end
    else if (bcnt_reg <= 16'h0001)
    begin
      bcnt_reg <= div_reg; // RULE16
    end
    else
    begin
      bcnt_reg <= bcnt_reg - 16'h0001;
    end
  end

  assign baud_tick = (div_reg != umh_pkg::DIV_RST) &&
    (bcnt_reg <= 16'h0001); // RULE16

  // Edge of the external receive clock
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rclk_old_reg <= 1'b0;
    end
    else
    begin
      rclk_old_reg <= rclk_s2_reg;
    end
  end

  assign rclk_rise = rclk_s2_reg & ~rclk_old_reg; // RULE14
  // Receiver takes the pin or the internal divider
  assign rx_tick =
    modem_control_reg[umh_pkg::CTRL_RX_INT] ? baud_tick : rclk_rise;

  // Tick outputs and bit phase counter
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      baud_clock_out <= 1'b0;
      rx_sample_tick_out <= 1'b0;
      rx_bit_tick_out <= 1'b0;
      ovs_reg <= 4'h0;
    end
    else
    begin
      baud_clock_out <= baud_tick; // RULE16
      rx_sample_tick_out <= rx_tick; // RULE14
      rx_bit_tick_out <= 1'b0;
      if (rx_tick)
      begin
        // Sixteen samples make one bit time
        if (ovs_reg == 4'(umh_pkg::RX_OVERSAMPLE - 1))
        begin
          ovs_reg <= 4'h0;
          rx_bit_tick_out <= 1'b1; // RULE14
        end
        else
        begin
          ovs_reg <= ovs_reg + 4'h1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// [design/umh_pkg.sv]
// Shared constants and carrier types for the modem and host pin logic
package umh_pkg;

  // Bus widths
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int IRQ_W = 4;
  localparam int DIV_W = 16;

  // Register offsets on the host port
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_DIV_LO = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_DIV_HI = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_MODEM_CTRL = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_MODEM_STAT = 3'h6;

  // Modem control field positions
  localparam int CTRL_DTR = 0;
  localparam int CTRL_RTS = 1;
  localparam int CTRL_OUT_A = 2;
  localparam int CTRL_OUT_B = 3;
  localparam int CTRL_LOOP = 4;
  localparam int CTRL_RX_INT = 5;
  localparam int CTRL_W = 6;

  // Modem status field positions
  localparam int MSR_DDSR = 1;
  localparam int MSR_DDCD = 3;
  localparam int MSR_DSR = 5;
  localparam int MSR_DCD = 7;

  // Interrupt status and mask field positions
  localparam int IRQ_RX = 0;
  localparam int IRQ_THR = 1;
  localparam int IRQ_LINE = 2;
  localparam int IRQ_MODEM = 3;

  // Values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
  localparam logic [DIV_W-1:0] DIV_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // Receive clock is sixteen times the bit rate
  localparam int RX_OVERSAMPLE = 16;

  // One host bus cycle as seen at the pins
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
    logic cs_a;
    logic cs_b;
    logic cs_c_n;
  } umh_host_req_t;

  // Pins from the modem side, not synchronous to clock_in
  typedef struct packed {
    logic dcd_n;
    logic dsr_n;
    logic rclk;
  } umh_modem_pins_t;

  // Interrupt causes from the serial core, same clock
  typedef struct packed {
    logic line_error;
    logic rx_ready;
    logic rx_timeout;
    logic fifo_mode;
    logic thr_empty;
  } umh_core_evt_t;

endpackage

// [verification/umh_pin_assertions.sv]
// Concurrent checks on the pin logic ports
`timescale 1ns/1ps
`default_nettype none
module umh_pin_assertions
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire umh_pkg::umh_host_req_t host_in,
  input wire umh_pkg::umh_modem_pins_t modem_in,
  input wire umh_pkg::umh_core_evt_t core_in,
  input wire logic [umh_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe_out,
  input wire logic bus_driver_disable_out,
  input wire logic dtr_n_out,
  input wire logic user_output_a_n_out,
  input wire logic user_output_b_n_out,
  input wire logic irq_out
);
  logic rd_sel; // Selected read strobe
  logic wr_sel; // Selected write strobe
  logic loop_reg; // Loopback bit as last written
  logic [3:0] mask_reg; // Interrupt mask as last written
  assign rd_sel = host_in.rd & host_in.cs_a & host_in.cs_b & ~host_in.cs_c_n;
  assign wr_sel = host_in.wr & host_in.cs_a & host_in.cs_b & ~host_in.cs_c_n;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Shadow of control and mask writes
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      loop_reg <= 1'b0;
      mask_reg <= 4'h0;
    end
    else if (wr_sel && host_in.addr == umh_pkg::OFF_MODEM_CTRL)
      loop_reg <= host_in.wdata[umh_pkg::CTRL_LOOP];
    else if (wr_sel && host_in.addr == umh_pkg::OFF_IRQ_MASK)
      mask_reg <= host_in.wdata[3:0];
  end
  sequence quiet;
    $stable(modem_in.dcd_n) && $stable(modem_in.dsr_n) && !loop_reg;
  endsequence
  sequence msr_read;
    rd_sel && host_in.addr == umh_pkg::OFF_MODEM_STAT;
  endsequence
  sequence ctrl_write;
    wr_sel && host_in.addr == umh_pkg::OFF_MODEM_CTRL;
  endsequence
  AST_OE_ON: assert property (rd_sel |=> data_oe_out)
    else $error("no drive after read");
  AST_OE_OFF: assert property (!rd_sel |=> !data_oe_out)
    else $error("drive without read");
  AST_DIS: assert property (bus_driver_disable_out == !$past(rd_sel))
    else $error("driver disable wrong");
  AST_DTR: assert property (ctrl_write |-> ##2
    dtr_n_out == !($past(host_in.wdata[0], 2) && !$past(host_in.wdata[4], 2)))
    else $error("terminal ready wrong");
  AST_USER: assert property (ctrl_write |-> ##2
    {user_output_b_n_out, user_output_a_n_out} ==
    ~($past(host_in.wdata[3:2], 2) & {2{!$past(host_in.wdata[4], 2)}}))
    else $error("user outputs wrong");
  AST_MSR_LEVEL: assert property (quiet [*5] ##0 msr_read |=>
    data_out[7] == !$past(modem_in.dcd_n) && data_out[5] == !$past(modem_in.dsr_n))
    else $error("status levels wrong");
  AST_MSR_CLEAR: assert property (quiet [*5] ##0 msr_read ##1
    quiet [*2] ##0 msr_read |=> data_out[3] == 1'b0 && data_out[1] == 1'b0)
    else $error("change flags not cleared");
  AST_IRQ_CAUSE: assert property ((core_in.thr_empty && mask_reg[1]) ||
    (core_in.line_error && mask_reg[2]) || (core_in.rx_ready && mask_reg[0])
    |-> ##[0:2] irq_out)
    else $error("interrupt missing");
  AST_IRQ_MASKED: assert property (mask_reg == 4'h0 |-> !irq_out)
    else $error("masked interrupt raised");
endmodule
bind umh_pin_logic umh_pin_assertions umh_pin_assertions_inst
(
  .clock_in(clock_in),
  .rst_in(rst_in),
  .host_in(host_in),
  .modem_in(modem_in),
  .core_in(core_in),
  .data_out(data_out),
  .data_oe_out(data_oe_out),
  .bus_driver_disable_out(bus_driver_disable_out),
  .dtr_n_out(dtr_n_out),
  .user_output_a_n_out(user_output_a_n_out),
  .user_output_b_n_out(user_output_b_n_out),
  .irq_out(irq_out)
);
`default_nettype wire

// [verification/umh_modem_model.sv]
// Modem side model: carrier, ready and receive clock pins
`timescale 1ns/1ps
`default_nettype none
module umh_modem_model
(
  input wire logic clock_in,
  input wire logic dcd_on_in,
  input wire logic dsr_on_in,
  input wire logic rclk_on_in,
  output logic [2:0] modem_out
);
  logic [1:0] phase_reg; // Receive clock phase, idle at zero
  logic dcd_n_reg; // Carrier pin, active low
  logic dsr_n_reg; // Ready pin, active low
  // Pins move just after the edge; clock stands low outside bursts
  always_ff @(posedge clock_in)
  begin
    phase_reg <= rclk_on_in ? phase_reg + 2'h1 : 2'h0;
    dcd_n_reg <= ~dcd_on_in;
    dsr_n_reg <= ~dsr_on_in;
  end
  assign modem_out = {dcd_n_reg, dsr_n_reg, phase_reg[1]};
endmodule
`default_nettype wire

// [verification/umh_pin_logic_bench.sv]
// Self-checking bench for the modem and host pin logic
`timescale 1ns/1ps
`default_nettype none
`define chk(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  $display("Error %0t: got %h want %h", $time, a, b); bad_count++; end end
module umh_pin_logic_bench;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  umh_pkg::umh_host_req_t host;
  umh_pkg::umh_modem_pins_t modem;
  umh_pkg::umh_core_evt_t core = '0;
  logic [7:0] data;
  logic oe, dis, dtr_n, ua_n, ub_n, irq, baud, stick, btick;
  logic dcd_on = 1'b0, dsr_on = 1'b0, rclk_on = 1'b0;
  int bad_count = 0, samples_checked = 0, nb = 0, ns = 0, nt = 0, b0, s0;
  // Control values and expected {dtr, user a, user b} levels
  logic [7:0] mv [6] = '{8'h0d, 8'h1d, 8'h01, 8'h04, 8'h08, 8'h00};
  logic [2:0] me [6] = '{3'b000, 3'b111, 3'b011, 3'b101, 3'b110, 3'b111};
  // Cause patterns and expected status bits
  logic [4:0] cv [5] = '{5'h08, 5'h06, 5'h04, 5'h01, 5'h10};
  logic [3:0] ce [5] = '{4'h1, 4'h1, 4'h0, 4'h2, 4'h4};
  logic [2:0] cs [3] = '{3'b010, 3'b100, 3'b111};
  always #50 clock_in = ~clock_in;
  // Pulse counters for the timing outputs
  always @(negedge clock_in)
  begin
    nb += baud;
    ns += stick;
    nt += btick;
  end
  umh_pin_logic umh_pin_logic_inst (.clock_in(clock_in), .rst_in(rst_in),
    .host_in(host), .modem_in(modem), .core_in(core), .data_out(data),
    .data_oe_out(oe), .bus_driver_disable_out(dis), .dtr_n_out(dtr_n),
    .user_output_a_n_out(ua_n), .user_output_b_n_out(ub_n), .irq_out(irq),
    .baud_clock_out(baud), .rx_sample_tick_out(stick), .rx_bit_tick_out(btick));
  umh_modem_model umh_modem_model_inst (.clock_in(clock_in),
    .dcd_on_in(dcd_on), .dsr_on_in(dsr_on), .rclk_on_in(rclk_on),
    .modem_out(modem));
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_in);
    host.addr <= a;
    host.wdata <= d;
    host.wr <= 1'b1;
    @(posedge clock_in);
    host.wr <= 1'b0;
  endtask
  // Read; s says whether the device is selected
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic s);
    @(posedge clock_in);
    host.addr <= a;
    host.rd <= 1'b1;
    @(posedge clock_in);
    host.rd <= 1'b0;
    @(negedge clock_in);
    `chk({oe, dis}, {s, !s})
    if (s)
      `chk(data, e)
  endtask
  task automatic end_sim;
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    tick(20000);
    bad_count++;
    end_sim();
  end
  initial
  begin
    host = '0;
    host.cs_a = 1'b1;
    host.cs_b = 1'b1;
    tick(4);
    rst_in <= 1'b0;
    @(negedge clock_in);
    `chk({dtr_n, ua_n, ub_n, irq, oe, dis}, 6'b111001)
    wr(umh_pkg::OFF_IRQ_MASK, 8'h08);
    dcd_on <= 1'b1;
    tick(6);
    rd(umh_pkg::OFF_MODEM_STAT, 8'h88, 1'b1);
    `chk(irq, 1'b1)
    rd(umh_pkg::OFF_MODEM_STAT, 8'h80, 1'b1);
    dsr_on <= 1'b1;
    tick(6);
    rd(umh_pkg::OFF_MODEM_STAT, 8'ha2, 1'b1);
    rd(umh_pkg::OFF_MODEM_STAT, 8'ha0, 1'b1);
    wr(umh_pkg::OFF_IRQ_STAT, 8'h08);
    @(negedge clock_in);
    `chk(irq, 1'b0)
    wr(umh_pkg::OFF_IRQ_MASK, 8'h0f);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clock_in);
      core <= cv[i];
      tick(2);
      rd(umh_pkg::OFF_IRQ_STAT, {4'h0, ce[i]}, 1'b1);
      `chk(irq, |ce[i])
      @(posedge clock_in);
      core <= '0;
      wr(umh_pkg::OFF_IRQ_STAT, 8'h0f);
      @(negedge clock_in);
      `chk(irq, 1'b0)
    end
    for (int i = 0; i < 6; i++)
    begin
      wr(umh_pkg::OFF_MODEM_CTRL, mv[i]);
      tick(2);
      @(negedge clock_in);
      `chk({dtr_n, ua_n, ub_n}, me[i])
    end
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clock_in);
      {host.cs_a, host.cs_b, host.cs_c_n} <= cs[i];
      wr(umh_pkg::OFF_MODEM_CTRL, 8'h01);
      rd(umh_pkg::OFF_MODEM_CTRL, 8'h00, 1'b0);
      `chk(dtr_n, 1'b1)
    end
    @(posedge clock_in);
    {host.cs_a, host.cs_b, host.cs_c_n} <= 3'b110;
    rd(3'h5, 8'h00, 1'b1);
    wr(umh_pkg::OFF_DIV_LO, 8'h03);
    wr(umh_pkg::OFF_DIV_HI, 8'h00);
    rd(umh_pkg::OFF_DIV_LO, 8'h03, 1'b1);
    tick(5);
    b0 = nb;
    tick(30);
    `chk(nb - b0, 10)
    wr(umh_pkg::OFF_MODEM_CTRL, 8'h01);
    wr(umh_pkg::OFF_IRQ_MASK, 8'h00);
    core <= 5'h01;
    tick(3);
    @(negedge clock_in);
    `chk(irq, 1'b0)
    wr(umh_pkg::OFF_IRQ_MASK, 8'h02);
    @(negedge clock_in);
    `chk(irq, 1'b1)
    @(posedge clock_in);
    rst_in <= 1'b1;
    tick(2);
    @(negedge clock_in);
    `chk({irq, dtr_n, oe, dis, data}, 12'h500)
    @(posedge clock_in);
    rst_in <= 1'b0;
    core <= '0;
    s0 = ns;
    b0 = nt;
    @(posedge clock_in);
    rclk_on <= 1'b1;
    tick(128);
    rclk_on <= 1'b0;
    tick(10);
    `chk(ns - s0, 32)
    `chk(nt - b0, 2)
    end_sim();
  end
endmodule
`default_nettype wire
